// >>> rtl/ssr_params.svh
// constants for the status byte and service request block
`ifndef SSR_PARAMS_SVH
`define SSR_PARAMS_SVH

// status byte bit positions
`define SSR_BIT_UNUSED0 0
`define SSR_BIT_UNUSED1 1
`define SSR_BIT_ERRQ 2
`define SSR_BIT_QUES 3
`define SSR_BIT_MAV 4
`define SSR_BIT_ESB 5
`define SSR_BIT_MSS 6
`define SSR_BIT_OPER 7

// register widths
`define SSR_BYTE_W 8
`define SSR_QUES_W 16
`define SSR_OPER_W 16
`define SSR_ESR_W 8

// reset values
`define SSR_STB_RESET 8'h00
`define SSR_SRE_RESET 8'h00
`define SSR_RESP_RESET 8'h00

// enable positions that a write may change (0 and 1 stay zero)
`define SSR_SRE_WMASK 8'hFC
// status byte positions that may raise a request (6, 1 and 0 excluded)
`define SSR_REQ_MASK 8'hBC

// width of the undelivered request counter
`define SSR_REQ_CNT_W 4

`endif

// >>> rtl/ssr_pkg.sv
// types shared by the status byte and service request block
`include "ssr_params.svh"

package ssr_pkg;

  // commands arriving from the remote command parser
  typedef enum logic [1:0] {
    ssr_cmd_stb_query,
    ssr_cmd_sre_write,
    ssr_cmd_sre_query,
    ssr_cmd_serial_poll
  } ssr_cmd_code_type;

  // one command with its data byte
  typedef struct packed {
    logic valid;
    ssr_cmd_code_type code;
    logic [`SSR_BYTE_W-1:0] data;
  } ssr_cmd_type;

  // one answer byte
  typedef struct packed {
    logic valid;
    logic [`SSR_BYTE_W-1:0] data;
  } ssr_resp_type;

  // inputs from the lower registers and the queues
  typedef struct packed {
    logic [`SSR_QUES_W-1:0] ques_event;
    logic [`SSR_QUES_W-1:0] ques_enable;
    logic [`SSR_OPER_W-1:0] oper_event;
    logic [`SSR_OPER_W-1:0] oper_enable;
    logic [`SSR_ESR_W-1:0] esr_event;
    logic [`SSR_ESR_W-1:0] ese_enable;
    logic errq_nonempty;
    logic errq_push;
    logic msg_pending;
  } ssr_lower_type;

endpackage : ssr_pkg

// >>> rtl/ssr_summary_bit.sv
// sum bit of one lower register: or over event and enable
`timescale 1ns/10ps

module ssr_summary_bit #(
  parameter int WIDTH = 16
) (
  // register parts
  input wire logic [WIDTH-1:0] event_bits,
  input wire logic [WIDTH-1:0] enable_bits,
  // summary
  output logic summary
);

  // and each event with its enable, then or the lot
  assign summary = |(event_bits & enable_bits);

endmodule : ssr_summary_bit

// >>> rtl/ssr_status_byte.sv
// status byte, request enable register and service request generation
//
// How it works
// - bit 6 of the status byte is the summary of the other enabled bits
// - status byte query and serial poll both return the status byte
// - each status bit pairs with its enable bit; enable bit 6 ignored
// - an enabled status bit rising 0 to 1 raises a service request
// - enable register written by command, stored, and returned on query
// - bit 2 set when an entry enters the error queue
// - with bit 2 enabled, each new error entry adds one request until the count saturates; an enabled bit rising in that cycle shares it
// - bit 3 set when any enabled questionable event bit is set
// - bit 4 set while a readable message waits in the output queue
// - bit 5 set when any enabled standard event bit is set
// - bit 6 set when a request is due: an enabled bit is set
// - bit 7 set when any enabled operation event bit is set
// - each summary bit is or over event bits anded with enables
// - event summary bit follows the level of enabled event status bits
`timescale 1ns/10ps
`include "ssr_params.svh"

module ssr_status_byte #(
  parameter int REQ_CNT_W = `SSR_REQ_CNT_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // command from the remote parser
  input wire ssr_pkg::ssr_cmd_type cmd,
  // lower registers and queues
  input wire ssr_pkg::ssr_lower_type lower,
  // answer to queries and polls
  output ssr_pkg::ssr_resp_type resp_q,
  // service request towards the controller
  output logic service_request_q,
  // live copies for observation
  output logic [`SSR_BYTE_W-1:0] status_summary_byte_q,
  output logic [`SSR_BYTE_W-1:0] request_enable_mask_q
);

  // write and request masks
  localparam logic [`SSR_BYTE_W-1:0] SRE_WMASK = `SSR_SRE_WMASK;
  localparam logic [`SSR_BYTE_W-1:0] REQ_MASK = `SSR_REQ_MASK;

  // reset values
  localparam logic [`SSR_BYTE_W-1:0] STB_RESET = `SSR_STB_RESET;
  localparam logic [`SSR_BYTE_W-1:0] SRE_RESET = `SSR_SRE_RESET;
  localparam logic [`SSR_BYTE_W-1:0] RESP_RESET = `SSR_RESP_RESET;

  // request counter end points
  localparam logic [REQ_CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [REQ_CNT_W-1:0] CNT_ONE = REQ_CNT_W'(1);
  localparam logic [REQ_CNT_W-1:0] CNT_MAX = '1;

  // reset synchroniser
  logic rst_meta_d;
  logic rst_meta_q;
  logic rst_sync_d;
  logic rst_sync_q;

  // summaries of the lower registers
  logic ques_sum;
  logic oper_sum;
  logic esr_sum;

  // status byte state
  logic [`SSR_BYTE_W-1:0] stb_d;
  logic [`SSR_BYTE_W-1:0] stb_q;
  logic [`SSR_BYTE_W-1:0] enabled_bits;
  logic [`SSR_BYTE_W-1:0] rising_bits;
  logic new_request;

  // request event sources
  logic edge_request;
  logic entry_request;

  // request enable state
  logic [`SSR_BYTE_W-1:0] sre_d;
  logic [`SSR_BYTE_W-1:0] sre_q;

  // undelivered request counter
  logic poll_retire;
  logic [REQ_CNT_W-1:0] req_cnt_kept;
  logic [REQ_CNT_W-1:0] req_cnt_d;
  logic [REQ_CNT_W-1:0] req_cnt_q;
  logic service_request_d;

  // answer state
  ssr_pkg::ssr_resp_type resp_d;

  // command decode
  logic cmd_stb_query;
  logic cmd_sre_write;
  logic cmd_sre_query;
  logic cmd_poll;

  // synchroniser next values: only the second stage reads the first
  always_comb begin
    rst_meta_d = 1'b1;
    rst_sync_d = rst_meta_q;
  end

  // release of the external reset through two flip-flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= rst_meta_d;
      rst_sync_q <= rst_sync_d;
    end
  end

  // questionable register sum bit
  ssr_summary_bit #(
    .WIDTH(`SSR_QUES_W)
  ) u_ques_sum (
    .event_bits(lower.ques_event),
    .enable_bits(lower.ques_enable),
    .summary(ques_sum)
  );

  // operation register sum bit
  ssr_summary_bit #(
    .WIDTH(`SSR_OPER_W)
  ) u_oper_sum (
    .event_bits(lower.oper_event),
    .enable_bits(lower.oper_enable),
    .summary(oper_sum)
  );

  // standard event register sum bit
  ssr_summary_bit #(
    .WIDTH(`SSR_ESR_W)
  ) u_esr_sum (
    .event_bits(lower.esr_event),
    .enable_bits(lower.ese_enable),
    .summary(esr_sum)
  );

  // command decode, one command per cycle at most
  always_comb begin
    cmd_stb_query = 1'b0;
    cmd_sre_write = 1'b0;
    cmd_sre_query = 1'b0;
    cmd_poll = 1'b0;
    if (cmd.valid) begin
      case (cmd.code)
        ssr_pkg::ssr_cmd_stb_query: begin
          cmd_stb_query = 1'b1;
        end
        ssr_pkg::ssr_cmd_sre_write: begin
          cmd_sre_write = 1'b1;
        end
        ssr_pkg::ssr_cmd_sre_query: begin
          cmd_sre_query = 1'b1;
        end
        ssr_pkg::ssr_cmd_serial_poll: begin
          cmd_poll = 1'b1;
        end
        default: begin
          // every code is listed above; all strobes stay low
          cmd_poll = 1'b0;
        end
      endcase
    end
  end

  // next status byte from the lower summaries
  always_comb begin
    stb_d = STB_RESET;
    // unused positions stay zero
    stb_d[`SSR_BIT_UNUSED0] = 1'b0;
    stb_d[`SSR_BIT_UNUSED1] = 1'b0;
    // a push counts at once, before the level catches up
    stb_d[`SSR_BIT_ERRQ] = lower.errq_nonempty | lower.errq_push;
    // bits 3, 5 and 7 carry the lower register sums
    stb_d[`SSR_BIT_QUES] = ques_sum;
    stb_d[`SSR_BIT_MAV] = lower.msg_pending;
    stb_d[`SSR_BIT_ESB] = esr_sum;
    stb_d[`SSR_BIT_OPER] = oper_sum;
    // pair each bit with its enable, enable bit 6 never counts
    enabled_bits = stb_d & sre_q & REQ_MASK;
    // main summary is the or of the other enabled bits
    stb_d[`SSR_BIT_MSS] = |enabled_bits;
  end

  // request events: enabled rising bits and each error entry while bit 2 is enabled
  always_comb begin
    rising_bits = stb_d & ~stb_q & sre_q & REQ_MASK;
    // several rising bits in one cycle make one request
    edge_request = |rising_bits;
    // every entry pushed while bit 2 is enabled is a request, shared with any enabled bit rising in the same cycle
    entry_request = lower.errq_push & sre_q[`SSR_BIT_ERRQ];
    new_request = edge_request | entry_request;
  end

  // status byte register
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      stb_q <= STB_RESET;
    end else begin
      stb_q <= stb_d;
    end
  end

  // enable register next value, low two bits dropped on write
  always_comb begin
    sre_d = sre_q;
    // bit 6 is stored but never forms a request
    if (cmd_sre_write) begin
      sre_d = cmd.data & SRE_WMASK;
    end
  end

  // enable register
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sre_q <= SRE_RESET;
    end else begin
      sre_q <= sre_d;
    end
  end

  // request counter: a poll retires one, a new event adds one
  always_comb begin
    // a poll hands one pending request to the controller
    poll_retire = cmd_poll && (req_cnt_q != CNT_ZERO);
    req_cnt_kept = req_cnt_q;
    if (poll_retire) begin
      req_cnt_kept = req_cnt_q - CNT_ONE;
    end
    // nothing enabled left set: drop stale requests
    if (!stb_d[`SSR_BIT_MSS]) begin
      req_cnt_kept = CNT_ZERO;
    end
    // a new event adds one after the poll and the drop are applied; the count saturates
    req_cnt_d = req_cnt_kept;
    if (new_request && (req_cnt_kept != CNT_MAX)) begin
      req_cnt_d = req_cnt_kept + CNT_ONE;
    end
    // the line stays up while any request is undelivered
    service_request_d = (req_cnt_d != CNT_ZERO);
  end

  // request counter
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      req_cnt_q <= CNT_ZERO;
    end else begin
      req_cnt_q <= req_cnt_d;
    end
  end

  // request line, registered so the pin never glitches
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      service_request_q <= 1'b0;
    end else begin
      service_request_q <= service_request_d;
    end
  end

  // answer byte for queries and polls
  always_comb begin
    // idle cycles give no strobe and zero data
    resp_d.valid = 1'b0;
    resp_d.data = RESP_RESET;
    if (cmd_stb_query || cmd_poll) begin
      resp_d.valid = 1'b1;
      resp_d.data = stb_q;
    end else if (cmd_sre_query) begin
      resp_d.valid = 1'b1;
      resp_d.data = sre_q;
    end
  end

  // answer register
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      resp_q.valid <= 1'b0;
      resp_q.data <= RESP_RESET;
    end else begin
      resp_q <= resp_d;
    end
  end

  // observation copy of the status byte
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      status_summary_byte_q <= STB_RESET;
    end else begin
      status_summary_byte_q <= stb_d;
    end
  end

  // observation copy of the enable register
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      request_enable_mask_q <= SRE_RESET;
    end else begin
      request_enable_mask_q <= sre_d;
    end
  end

endmodule : ssr_status_byte

// >>> tb/ssr_status_byte_sva.sv
// assertions on the status byte block ports
`timescale 1ns/10ps

module ssr_status_byte_sva #(
  parameter int REQ_CNT_W = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // inputs
  input wire ssr_pkg::ssr_cmd_type cmd,
  input wire ssr_pkg::ssr_lower_type lower,
  // outputs
  input wire ssr_pkg::ssr_resp_type resp_q,
  input wire logic service_request_q,
  input wire logic [7:0] status_summary_byte_q,
  input wire logic [7:0] request_enable_mask_q
);
  logic [1:0] up_q;
  logic [1:0] up_d;
  logic ok;
  logic [7:0] sb;
  logic [7:0] en;
  logic ques_sum;
  logic oper_sum;
  logic esr_sum;
  // short names and settle window after reset
  assign sb = status_summary_byte_q;
  assign en = request_enable_mask_q;
  // lower register sums, kept as signals for the sampled history
  assign ques_sum = |(lower.ques_event & lower.ques_enable);
  assign oper_sum = |(lower.oper_event & lower.oper_enable);
  assign esr_sum = |(lower.esr_event & lower.ese_enable);
  assign ok = up_q == 2'h3;
  always_comb up_d = ok ? up_q : up_q + 2'h1;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) up_q <= 2'h0;
    else up_q <= up_d;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // status byte requests
  sequence s_query;
    ok && cmd.valid && cmd.code inside {ssr_pkg::ssr_cmd_stb_query, ssr_pkg::ssr_cmd_serial_poll};
  endsequence
  property p_zero; ok |-> sb[1:0] == 2'h0 && en[1:0] == 2'h0; endproperty
  a_zero: assert property (p_zero) else $error("unused bits set");
  property p_main; ok |-> sb[6] == |(sb & 8'hBC & $past(en)); endproperty
  a_main: assert property (p_main) else $error("main summary wrong");
  property p_mav; ok |-> sb[4] == $past(lower.msg_pending); endproperty
  a_mav: assert property (p_mav) else $error("message bit wrong");
  property p_ques; ok |-> sb[3] == $past(ques_sum); endproperty
  a_ques: assert property (p_ques) else $error("questionable bit wrong");
  property p_esb; ok |-> sb[5] == $past(esr_sum); endproperty
  a_esb: assert property (p_esb) else $error("event bit wrong");
  property p_oper; ok |-> sb[7] == $past(oper_sum); endproperty
  a_oper: assert property (p_oper) else $error("operation bit wrong");
  property p_errq; ok && lower.errq_push |=> sb[2]; endproperty
  a_errq: assert property (p_errq) else $error("error bit not set");
  property p_ans; s_query |=> resp_q.valid && resp_q.data == $past(sb); endproperty
  a_ans: assert property (p_ans) else $error("status answer wrong");
  property p_wr;
    ok && cmd.valid && cmd.code == ssr_pkg::ssr_cmd_sre_write |=> en == ($past(cmd.data) & 8'hFC);
  endproperty
  a_wr: assert property (p_wr) else $error("enable write wrong");
  property p_req; ok && $rose(sb[2]) && $stable(en) && en[2] |-> service_request_q; endproperty
  a_req: assert property (p_req) else $error("no request");
  property p_clr; ok && !sb[6] |-> !service_request_q; endproperty
  a_clr: assert property (p_clr) else $error("request stuck");
endmodule : ssr_status_byte_sva

bind ssr_status_byte ssr_status_byte_sva #(.REQ_CNT_W(REQ_CNT_W)) ssr_status_byte_sva_inst (
  .mclk(mclk), .resetn(resetn), .cmd(cmd), .lower(lower), .resp_q(resp_q),
  .service_request_q(service_request_q), .status_summary_byte_q(status_summary_byte_q),
  .request_enable_mask_q(request_enable_mask_q));

// >>> tb/ssr_ctrl_model.sv
// remote controller model issuing commands
`timescale 1ns/10ps

module ssr_ctrl_model (
  // clock
  input wire logic mclk,
  // command out, answer in
  output ssr_pkg::ssr_cmd_type cmd,
  input wire ssr_pkg::ssr_resp_type resp_q
);
  initial cmd = '0;
  // one command after gap plus one idle cycles; data byte scrambled once released
  task automatic send(input ssr_pkg::ssr_cmd_code_type code, input logic [7:0] d,
                      input int gap, output ssr_pkg::ssr_resp_type resp);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    #1 cmd = '{1'b1, code, d};
    @(posedge mclk);
    #1 cmd = '{1'b0, code, ~d};
    resp = resp_q;
  endtask : send
endmodule : ssr_ctrl_model

// >>> tb/status_byte_service_request_bench.sv
// bench for the status byte block
`timescale 1ns/10ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch at %0t: got %h exp %h", $time, got, exp); end end

module status_byte_service_request_bench;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  ssr_pkg::ssr_cmd_type cmd;
  ssr_pkg::ssr_lower_type lower = '0;
  ssr_pkg::ssr_resp_type resp_q;
  ssr_pkg::ssr_resp_type r;
  logic srq;
  logic [7:0] sb;
  logic [7:0] en;
  logic [7:0] tbl [3] = '{8'h48, 8'hC0, 8'h60};
  int miscompares = 0;
  int compares = 0;
  always #25 mclk = ~mclk;
  // design and controller model
  ssr_status_byte #(.REQ_CNT_W(2)) ssr_status_byte_inst (.mclk(mclk), .resetn(resetn),
    .cmd(cmd), .lower(lower), .resp_q(resp_q), .service_request_q(srq),
    .status_summary_byte_q(sb), .request_enable_mask_q(en));
  ssr_ctrl_model ssr_ctrl_model_inst (.mclk(mclk), .cmd(cmd), .resp_q(resp_q));
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // status query or poll, then the request line
  task automatic q(input ssr_pkg::ssr_cmd_code_type c, input logic [7:0] e, input logic l);
    ssr_ctrl_model_inst.send(c, 8'h00, 2, r);
    `CHK(r.valid, 1'b1)
    `CHK(r.data, e)
    `CHK(sb, e)
    `CHK(srq, l)
  endtask : q
  // enable write then read back
  task automatic request_enable_mask(input logic [7:0] d);
    ssr_ctrl_model_inst.send(ssr_pkg::ssr_cmd_sre_write, d, 0, r);
    ssr_ctrl_model_inst.send(ssr_pkg::ssr_cmd_sre_query, 8'h00, 0, r);
    `CHK(r.valid, 1'b1)
    `CHK(r.data, d & 8'hFC)
    `CHK(en, d & 8'hFC)
  endtask : request_enable_mask
  initial begin
    #50000;
    miscompares++;
    complete_run();
  end
  // main sequence
  initial begin
    repeat (2) @(posedge mclk);
    #1 resetn = 1'b1;
    repeat (3) @(posedge mclk);
    request_enable_mask(8'hFF);
    lower.msg_pending = 1'b1;
    q(ssr_pkg::ssr_cmd_stb_query, 8'h50, 1'b1);
    lower = '{ques_event: 16'h8000, oper_event: 16'h0008, esr_event: 8'h80, default: '0};
    q(ssr_pkg::ssr_cmd_stb_query, 8'h00, 1'b0);
    for (int i = 0; i < 3; i++) begin
      lower.ques_enable = (i == 0) ? 16'h8000 : 16'h0000;
      lower.oper_enable = (i == 1) ? 16'h0008 : 16'h0000;
      lower.ese_enable = (i == 2) ? 8'hFF : 8'h00;
      q(ssr_pkg::ssr_cmd_stb_query, tbl[i], 1'b1);
    end
    lower = '{msg_pending: 1'b1, default: '0};
    request_enable_mask(8'h40);
    q(ssr_pkg::ssr_cmd_stb_query, 8'h10, 1'b0);
    lower.msg_pending = 1'b0;
    request_enable_mask(8'h04);
    lower.errq_push = 1'b1;
    lower.errq_nonempty = 1'b1;
    repeat (2) @(posedge mclk);
    #1 lower.errq_push = 1'b0;
    q(ssr_pkg::ssr_cmd_serial_poll, 8'h44, 1'b1);
    q(ssr_pkg::ssr_cmd_serial_poll, 8'h44, 1'b0);
    q(ssr_pkg::ssr_cmd_stb_query, 8'h44, 1'b0);
    complete_run();
  end
endmodule : status_byte_service_request_bench
